/* verilog/vector_map_and_reset_config.sv */
/*
 * Vector map and reset configuration: picks the highest priority enabled
 * request and presents its vector above a relocatable base, holds the CPU
 * off while the option byte loads after reset, and derives the watchdog
 * rate and window setting from that byte.
 * Assumes request lines and the CPU mask bit come from logic on CLK_I, and
 * a flash loader that answers one option byte request with a valid pulse.
 * Register writes land on the edge at which the master sees ACK_O high.
 */
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps

module vector_map_and_reset_config (
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	// Wishbone slave
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	// Interrupt requests and CPU side
	input  wire logic [14:0] IRQ_REQ_I,
	input  wire logic        CPU_IMASK_I,
	output logic             VEC_VALID_O,
	output logic      [15:0] VEC_ADDR_O,
	output logic             WAKE_WAIT_O,
	output logic             WAKE_STOP_O,
	output logic             CPU_STALL_O,
	// Flash configuration loader
	output logic             CFG_REQ_O,
	input  wire logic        CFG_VALID_I,
	input  wire logic [7:0]  CFG_DATA_I,
	input  wire logic        CFG_DFAULT_I,
	output logic             FLASH_ABORT_O,
	output logic             FLASH_PROTECT_O,
	output logic             FLASH_SECURE_O,
	// Watchdog settings and misc
	output logic      [2:0]  WDOG_RATE_O,
	output logic             WDOG_WINDOW_O,
	output logic             PERIODIC_CLK_OUT_EN_O,
	output logic             IRQ_O
);

	// Register state
	logic [7:0]                         vector_base;
	logic [14:0]                        irq_enable;
	logic [7:0]                         watchdog_control;
	logic [vector_map_pkg::EVT_W-1:0]   evt_status;
	logic [vector_map_pkg::EVT_W-1:0]   evt_mask;
	vector_map_pkg::cfg_state_t         cfg;
	vector_map_pkg::seq_state_t         state;
	vector_map_pkg::seq_state_t         next_state;

	// Bus decode
	wire logic        bus_req;
	wire logic        wr_en;
	wire logic        rd_en;
	wire logic        wr_lane0;
	wire logic        wr_lane1;
	wire logic        hit_base;
	wire logic        hit_enable;
	wire logic        hit_pending;
	wire logic        hit_cfg;
	wire logic        hit_evt;
	wire logic        hit_mask;
	wire logic        hit_wdog;
	wire logic        wr_base;
	wire logic        wr_enable_lo;
	wire logic        wr_enable_hi;
	wire logic        wr_wdog;
	wire logic        wr_evt;
	wire logic        wr_mask;
	logic      [31:0] rd_data;

	assign bus_req    = CYC_I & STB_I & ~ACK_O;
	// A write lands on the edge at which the master sees ACK_O high
	assign wr_en      = CYC_I & STB_I & WE_I & ACK_O;
	assign rd_en      = bus_req & ~WE_I;
	assign wr_lane0   = wr_en & SEL_I[0];
	assign wr_lane1   = wr_en & SEL_I[1];
	assign hit_base   = ADR_I == vector_map_pkg::ADDR_VECTOR_BASE;
	assign hit_enable = ADR_I == vector_map_pkg::ADDR_IRQ_ENABLE;
	assign hit_pending = ADR_I == vector_map_pkg::ADDR_PENDING;
	assign hit_cfg    = ADR_I == vector_map_pkg::ADDR_CFG_STATUS;
	assign hit_evt    = ADR_I == vector_map_pkg::ADDR_EVT_STATUS;
	assign hit_mask   = ADR_I == vector_map_pkg::ADDR_EVT_MASK;
	assign hit_wdog   = ADR_I == vector_map_pkg::ADDR_WDOG_CTRL;

	// Register write strobes
	assign wr_base      = wr_lane0 & hit_base;
	assign wr_enable_lo = wr_lane0 & hit_enable;
	assign wr_enable_hi = wr_lane1 & hit_enable;
	assign wr_wdog      = wr_lane0 & hit_wdog;
	assign wr_evt       = wr_lane0 & hit_evt;
	assign wr_mask      = wr_lane0 & hit_mask;

	// Interrupt selection
	wire logic [14:0] active;
	wire logic        any_active;
	wire logic        wake_wait;
	wire logic        wake_stop;
	logic      [7:0]  sel_offset;
	wire logic [15:0] next_vec_addr;

	// Request only counts with its enable set and I bit clear
	assign active     = IRQ_REQ_I & irq_enable & {15{~CPU_IMASK_I}};
	assign any_active = |active;
	// Battery and supply overcurrent sit in the wait-only class
	assign wake_wait  = |(active & vector_map_pkg::WAKE_WAIT_MASK);
	assign wake_stop  = |(active & vector_map_pkg::WAKE_STOP_MASK);

	// Fixed priority: lowest index wins, reserved slots never listed
	always_comb begin
		sel_offset = vector_map_pkg::VEC_SPURIOUS;
		for (int i = vector_map_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (active[i]) begin
				sel_offset = vector_map_pkg::VEC_OFFSET[i];
			end
		end
	end

	// Vector address: base page above the slot offset
	assign next_vec_addr = {vector_base, sel_offset};

	// Configuration sequencer
	wire logic load_done;
	wire logic [2:0] opt_rate;
	wire logic       opt_window;

	assign load_done  = state == vector_map_pkg::ST_WAIT && CFG_VALID_I;
	// Watchdog fields are the inverse of the option bits
	assign opt_rate   = ~CFG_DATA_I[vector_map_pkg::OPT_RATE_LSB +: 3];
	assign opt_window = ~CFG_DATA_I[vector_map_pkg::OPT_WIN_BIT];

	// Next sequencer state
	always_comb begin
		next_state = state;
		unique case (state)
			vector_map_pkg::ST_REQ: begin
				next_state = vector_map_pkg::ST_WAIT;
			end
			vector_map_pkg::ST_WAIT: begin
				if (CFG_VALID_I) begin
					next_state = vector_map_pkg::ST_RUN;
				end
			end
			vector_map_pkg::ST_RUN: begin
				next_state = vector_map_pkg::ST_RUN;
			end
			// A code that is not one-hot restarts the load request
			default: begin
				next_state = vector_map_pkg::ST_REQ;
			end
		endcase
	end

	// Sequencer state, restarted by every reset
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state <= vector_map_pkg::ST_REQ;
		end else begin
			state <= next_state;
		end
	end

	// Configuration flags and loader request
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cfg       <= vector_map_pkg::CFG_RST;
			CFG_REQ_O <= 1'b0;
		end else begin
			CFG_REQ_O <= next_state == vector_map_pkg::ST_WAIT;
			if (load_done) begin
				cfg.loaded  <= 1'b1;
				cfg.protect <= CFG_DFAULT_I;
				cfg.secure  <= CFG_DFAULT_I;
			end
		end
	end

	// CPU held off until the load completes; abort flash on reset
	// Abort spans reset and the first edge, cutting a command in flight
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			CPU_STALL_O   <= 1'b1;
			FLASH_ABORT_O <= 1'b1;
		end else begin
			CPU_STALL_O   <= ~(cfg.loaded | load_done);
			FLASH_ABORT_O <= 1'b0;
		end
	end

	// Vector base and local enables
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			vector_base <= vector_map_pkg::VECTOR_BASE_RST;
			irq_enable  <= vector_map_pkg::IRQ_ENABLE_RST;
		end else begin
			if (wr_base) begin
				vector_base <= DAT_I[7:0];
			end
			if (wr_enable_lo) begin
				irq_enable[7:0] <= DAT_I[7:0];
			end
			if (wr_enable_hi) begin
				irq_enable[14:8] <= DAT_I[14:8];
			end
		end
	end

	// Watchdog control: option load wins over a bus write
	// A write in the load cycle is dropped; the option byte rules
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			watchdog_control <= vector_map_pkg::WDOG_CTRL_RST;
		end else if (load_done) begin
			watchdog_control[vector_map_pkg::WDOG_RATE_LSB +: 3] <=
				opt_rate;
			watchdog_control[vector_map_pkg::WDOG_WIN_BIT] <=
				opt_window;
		end else if (wr_wdog) begin
			watchdog_control <= DAT_I[7:0];
		end
	end

	// Event status: set wins over write-one-to-clear
	wire logic [vector_map_pkg::EVT_W-1:0] evt_set;
	wire logic [vector_map_pkg::EVT_W-1:0] evt_clr;
	wire logic [vector_map_pkg::EVT_W-1:0] evt_pending;

	assign evt_set = {load_done & CFG_DFAULT_I, load_done};
	assign evt_clr = wr_evt ?
		DAT_I[vector_map_pkg::EVT_W-1:0] : vector_map_pkg::EVT_RST;
	// Status bits that may raise the interrupt line
	assign evt_pending = evt_status & evt_mask;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			evt_status <= vector_map_pkg::EVT_RST;
			evt_mask   <= vector_map_pkg::EVT_RST;
		end else begin
			evt_status <= (evt_status & ~evt_clr) | evt_set;
			if (wr_mask) begin
				evt_mask <= DAT_I[vector_map_pkg::EVT_W-1:0];
			end
		end
	end

	// Read word of each register, zero above its width
	wire logic [31:0] rd_base;
	wire logic [31:0] rd_enable;
	wire logic [31:0] rd_pending;
	wire logic [31:0] rd_cfg;
	wire logic [31:0] rd_evt;
	wire logic [31:0] rd_mask;
	wire logic [31:0] rd_wdog;

	assign rd_base    = 32'(vector_base);
	assign rd_enable  = 32'(irq_enable);
	assign rd_pending = 32'(IRQ_REQ_I);
	assign rd_cfg     = 32'(cfg);
	assign rd_evt     = 32'(evt_status);
	assign rd_mask    = 32'(evt_mask);
	assign rd_wdog    = 32'(watchdog_control);

	// Read multiplexer; unmapped reads return zero
	assign rd_data = hit_base ? rd_base :
		hit_enable ? rd_enable :
		hit_pending ? rd_pending :
		hit_cfg ? rd_cfg :
		hit_evt ? rd_evt :
		hit_mask ? rd_mask :
		hit_wdog ? rd_wdog : 32'h0000_0000;

	// Bus answer one cycle after the request, held for one cycle
	// ACK_O masks the request, so a held strobe is answered every second cycle
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else begin
			ACK_O <= bus_req;
			if (rd_en) begin
				DAT_O <= rd_data;
			end
		end
	end

	// Registered vector and wake outputs
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			VEC_VALID_O <= 1'b0;
			VEC_ADDR_O  <= 16'h0000;
			WAKE_WAIT_O <= 1'b0;
			WAKE_STOP_O <= 1'b0;
		end else begin
			VEC_VALID_O <= any_active;
			VEC_ADDR_O  <= next_vec_addr;
			WAKE_WAIT_O <= wake_wait;
			WAKE_STOP_O <= wake_stop;
		end
	end

	// Registered status outputs
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			FLASH_PROTECT_O <= 1'b0;
			FLASH_SECURE_O  <= 1'b0;
			WDOG_RATE_O     <= 3'h0;
			WDOG_WINDOW_O   <= 1'b0;
			PERIODIC_CLK_OUT_EN_O <= 1'b0;
			IRQ_O           <= 1'b0;
		end else begin
			FLASH_PROTECT_O <= cfg.protect;
			FLASH_SECURE_O  <= cfg.secure;
			WDOG_RATE_O     <=
				watchdog_control[vector_map_pkg::WDOG_RATE_LSB +: 3];
			WDOG_WINDOW_O   <= watchdog_control[vector_map_pkg::WDOG_WIN_BIT];
			// Clock-out option absent on this variant
			PERIODIC_CLK_OUT_EN_O <= 1'b0;
			IRQ_O           <= |evt_pending;
		end
	end

	// No RAM array lives here: reset never clears or presets memory, and
	// software must not rely on memory contents after reset.

endmodule

/* verilog/vector_map_pkg.sv */
/*
 * Constants, register map and carrier types for the vector map and
 * reset configuration block.
 * Assumes a 32-bit classic Wishbone register bus on one 125 MHz clock.
 */
package vector_map_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_VECTOR_BASE = 8'h00;
	localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h04;
	localparam logic [7:0] ADDR_PENDING     = 8'h08;
	localparam logic [7:0] ADDR_CFG_STATUS  = 8'h0C;
	localparam logic [7:0] ADDR_EVT_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_EVT_MASK    = 8'h14;
	localparam logic [7:0] ADDR_WDOG_CTRL   = 8'h3C;

	// Reset values
	localparam logic [7:0]  VECTOR_BASE_RST = 8'hFF;
	localparam logic [14:0] IRQ_ENABLE_RST  = 15'h0000;
	localparam logic [7:0]  WDOG_CTRL_RST   = 8'h00;
	localparam logic [1:0]  EVT_RST         = 2'h0;

	// Watchdog control layout
	localparam int WDOG_RATE_LSB = 0;
	localparam int WDOG_RATE_W   = 3;
	localparam int WDOG_WIN_BIT  = 7;
	// Option byte layout
	localparam int OPT_RATE_LSB  = 0;
	localparam int OPT_WIN_BIT   = 3;

	// Event status bits
	localparam int EVT_LOADED = 0;
	localparam int EVT_DFAULT = 1;
	localparam int EVT_W      = 2;

	// Interrupt sources, index 0 has the highest priority
	localparam int NUM_SRC = 15;
	localparam int SRC_BATTERY = 7;
	localparam int SRC_SUPPLY_OC = 9;
	localparam logic [7:0] VEC_OFFSET [NUM_SRC] = '{
		8'hC8, 8'hC6, 8'hBA, 8'hB8, 8'hAE, 8'hAC, 8'hAA, 8'hA8,
		8'h8E, 8'h8C, 8'h8A, 8'h88, 8'h86, 8'h84, 8'h82};
	localparam logic [7:0] VEC_SPURIOUS = 8'h80;
	// Bit i set: source i may wake from stop / wait
	localparam logic [14:0] WAKE_STOP_MASK = 15'h5940;
	localparam logic [14:0] WAKE_WAIT_MASK = 15'h7FFB;

	// Vector address width
	localparam int VEC_W = 16;

	// Configuration state carried as one unit
	typedef struct packed {
		logic loaded;
		logic protect;
		logic secure;
	} cfg_state_t;

	localparam cfg_state_t CFG_RST = '{loaded: 1'b0, protect: 1'b0,
		secure: 1'b0};

	typedef enum logic [2:0] {
		ST_REQ  = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN  = 3'b100
	} seq_state_t;

endpackage

/* verif/vector_map_monitor.sv */
/* Checker for the vector map block, bound to its top ports.
   Assumes one clock and an active low asynchronous reset. */
`timescale 1ns/1ps
module vector_map_monitor (
	input wire logic        CLK_I,
	input wire logic        RESETN_I,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        ACK_O,
	input wire logic        CPU_IMASK_I,
	input wire logic        VEC_VALID_O,
	input wire logic [15:0] VEC_ADDR_O,
	input wire logic        CPU_STALL_O,
	input wire logic        CFG_REQ_O,
	input wire logic        CFG_VALID_I,
	input wire logic [7:0]  CFG_DATA_I,
	input wire logic        CFG_DFAULT_I,
	input wire logic        FLASH_ABORT_O,
	input wire logic        FLASH_PROTECT_O,
	input wire logic        FLASH_SECURE_O,
	input wire logic [2:0]  WDOG_RATE_O,
	input wire logic        WDOG_WINDOW_O,
	input wire logic        PERIODIC_CLK_OUT_EN_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Option byte taken this edge
	wire load = CFG_REQ_O && CFG_VALID_I;

	chk_bus_ack: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
		else $error("ack not a single pulse");
	chk_stall_hold: assert property (CPU_STALL_O && !load |=> CPU_STALL_O)
		else $error("stall dropped early");
	chk_stall_free: assert property (load |=> !CPU_STALL_O && !CFG_REQ_O)
		else $error("stall kept after load");
	chk_rate_load: assert property (load ##2 1 |->
		{WDOG_WINDOW_O, WDOG_RATE_O} == ~$past(CFG_DATA_I[3:0], 2))
		else $error("watchdog setting wrong");
	chk_fault_lock: assert property (load ##2 1 |->
		FLASH_PROTECT_O == $past(CFG_DFAULT_I, 2)
		&& FLASH_SECURE_O == $past(CFG_DFAULT_I, 2))
		else $error("protection not from fault");
	chk_abort_release: assert property ($rose(RESETN_I) |->
		FLASH_ABORT_O ##1 !FLASH_ABORT_O)
		else $error("abort timing wrong");
	chk_no_clk_out: assert property (!PERIODIC_CLK_OUT_EN_O)
		else $error("timer clock output enabled");
	chk_mask_blocks: assert property (CPU_IMASK_I |=> !VEC_VALID_O)
		else $error("masked request vectored");
	chk_vec_slot: assert property (VEC_VALID_O |-> !VEC_ADDR_O[0]
		&& VEC_ADDR_O[7:0] > 8'h80
		&& !(VEC_ADDR_O[7:0] inside {[8'h90:8'hA6]}))
		else $error("bad vector slot");
endmodule

bind vector_map_and_reset_config vector_map_monitor i_mon (.*);

/* verif/flash_cfg_model.sv */
/* Flash option byte loader model for the vector map bench.
   Assumes the block raises cfg_req_i once after each reset. */
`timescale 1ns/1ps
module flash_cfg_model #(
	parameter logic [7:0] OPT = 8'h5A,
	parameter int         LAT = 4
) (
	input  wire logic       CLK_I,
	input  wire logic       RESETN_I,
	input  wire logic       cfg_req_i,
	input  wire logic       fault_i,
	output logic            cfg_valid_o,
	output logic      [7:0] cfg_data_o,
	output logic            cfg_dfault_o
);
	int   cnt;
	logic sent;
	// One answer per reset; idle lines toggle every cycle
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cnt <= 0;
			sent <= 1'b0;
			cfg_valid_o <= 1'b0;
			cfg_data_o <= ~OPT;
			cfg_dfault_o <= ~fault_i;
		end else if (cfg_req_i && !sent && cnt == LAT) begin
			cfg_valid_o <= 1'b1;
			cfg_data_o <= OPT;
			cfg_dfault_o <= fault_i;
			sent <= 1'b1;
		end else begin
			cfg_valid_o <= 1'b0;
			cfg_data_o <= ~cfg_data_o;
			cfg_dfault_o <= ~cfg_dfault_o;
			cnt <= cfg_req_i ? cnt + 1 : cnt;
		end
	end
endmodule

/* verif/vector_map_and_reset_config_bench.sv */
/* Self-checking bench for the vector map and reset configuration block.
   Assumes the flash model answers the option byte request of each reset. */
`timescale 1ns/1ps
module vector_map_and_reset_config_bench;
	localparam logic [7:0] OPT = 8'h5A;
	localparam logic [2:0] RATE = ~OPT[2:0];
	localparam logic       WIN = ~OPT[3];
	logic CLK_I = 0, RESETN_I = 0, CYC_I = 0, STB_I = 0, WE_I = 0;
	logic CPU_IMASK_I = 0, CFG_VALID_I, CFG_DFAULT_I, fault = 0;
	logic [7:0] ADR_I = 0, CFG_DATA_I;
	logic [3:0] SEL_I = 4'h3;
	logic [31:0] DAT_I = 0, DAT_O, rd;
	logic [14:0] IRQ_REQ_I = 0;
	logic [15:0] VEC_ADDR_O;
	logic [2:0] WDOG_RATE_O;
	logic ACK_O, VEC_VALID_O, WAKE_WAIT_O, WAKE_STOP_O, CPU_STALL_O, IRQ_O;
	logic CFG_REQ_O, FLASH_ABORT_O, FLASH_PROTECT_O, FLASH_SECURE_O;
	logic WDOG_WINDOW_O, PERIODIC_CLK_OUT_EN_O;
	int miscompares = 0, tests_run = 0;

	vector_map_and_reset_config i_dut (.*);
	flash_cfg_model #(.OPT(OPT), .LAT(4)) i_flash (.CLK_I(CLK_I),
		.RESETN_I(RESETN_I), .cfg_req_i(CFG_REQ_O), .fault_i(fault),
		.cfg_valid_o(CFG_VALID_I), .cfg_data_o(CFG_DATA_I),
		.cfg_dfault_o(CFG_DFAULT_I));

	// Clock
	always #4 CLK_I = ~CLK_I;

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge CLK_I);
	endtask

	// One classic Wishbone cycle, held until ack is seen at a rising edge
	task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
		@(posedge CLK_I);
		CYC_I <= 1;
		STB_I <= 1;
		WE_I <= we;
		ADR_I <= adr;
		DAT_I <= dat;
		do begin
			@(posedge CLK_I);
		end while (ACK_O !== 1'b1);
		chk("ack", ACK_O, 1);
		rd = DAT_O;
		CYC_I <= 0;
		STB_I <= 0;
		@(posedge CLK_I);
	endtask

	// Reset, then wait for the option byte load to free the CPU
	task automatic do_reset(logic f);
		int n;
		n = 0;
		@(posedge CLK_I);
		RESETN_I <= 0;
		fault <= f;
		repeat (8) @(posedge CLK_I);
		chk("abort", FLASH_ABORT_O, 1);
		RESETN_I <= 1;
		tick(3);
		chk("stall", CPU_STALL_O, 1);
		while (CPU_STALL_O !== 1'b0 && n < 50) begin
			tick(1);
			n++;
		end
		chk("stall free", CPU_STALL_O, 0);
		tick(2);
	endtask

	// Main sequence
	initial begin
		do_reset(0);
		chk("rate", WDOG_RATE_O, RATE);
		chk("window", WDOG_WINDOW_O, WIN);
		chk("protect", FLASH_PROTECT_O, 0);
		chk("secure0", FLASH_SECURE_O, 0);
		chk("clkout", PERIODIC_CLK_OUT_EN_O, 0);
		wb(0, vector_map_pkg::ADDR_WDOG_CTRL, 0);
		chk("wdog reg", rd, {24'h0, WIN, 4'h0, RATE});
		wb(0, vector_map_pkg::ADDR_VECTOR_BASE, 0);
		chk("base rst", rd, 32'hFF);
		wb(0, 8'h20, 0);
		chk("unmapped", rd, 0);
		wb(0, vector_map_pkg::ADDR_EVT_STATUS, 0);
		chk("evt", rd, 1);
		wb(1, vector_map_pkg::ADDR_EVT_MASK, 1);
		tick(2);
		chk("irq on", IRQ_O, 1);
		wb(1, vector_map_pkg::ADDR_EVT_STATUS, 1);
		tick(2);
		chk("irq off", IRQ_O, 0);
		wb(1, vector_map_pkg::ADDR_VECTOR_BASE, 32'h12);
		wb(1, vector_map_pkg::ADDR_IRQ_ENABLE, 32'h280);
		IRQ_REQ_I <= 15'h0A80;
		tick(2);
		chk("vec bat", VEC_ADDR_O, 16'h12A8);
		chk("vec on", VEC_VALID_O, 1);
		chk("wait", WAKE_WAIT_O, 1);
		chk("stop", WAKE_STOP_O, 0);
		CPU_IMASK_I <= 1;
		tick(2);
		chk("masked", VEC_VALID_O, 0);
		CPU_IMASK_I <= 0;
		wb(1, vector_map_pkg::ADDR_IRQ_ENABLE, 32'h200);
		tick(2);
		chk("vec oc", VEC_ADDR_O, 16'h128C);
		chk("stop oc", WAKE_STOP_O, 0);
		wb(1, vector_map_pkg::ADDR_IRQ_ENABLE, 32'h800);
		tick(2);
		chk("vec api", VEC_ADDR_O, 16'h1288);
		chk("stop api", WAKE_STOP_O, 1);
		wb(1, vector_map_pkg::ADDR_IRQ_ENABLE, 0);
		tick(2);
		chk("gated", VEC_VALID_O, 0);
		do_reset(1);
		chk("secure", FLASH_SECURE_O, 1);
		chk("protect2", FLASH_PROTECT_O, 1);
		chk("vec rst", VEC_VALID_O, 0);
		wb(0, vector_map_pkg::ADDR_EVT_STATUS, 0);
		chk("evt fault", rd, 3);
		wb(0, vector_map_pkg::ADDR_VECTOR_BASE, 0);
		chk("base again", rd, 32'hFF);
		report_and_stop();
	end

	// Watchdog against a hang
	initial begin
		#40000;
		miscompares++;
		report_and_stop();
	end
endmodule
